// >>> include/dpr_pkg.sv
package dpr_pkg;
  localparam int CELLS = 4096;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 12;
  localparam int SLICE_W = 256;
  localparam int SLICES = 16;
  localparam int BASE_W = 13;
  localparam logic [DATA_W-1:0] OUT_RESET = 16'h0000;

  // one port's controls, already past polarity inversion, valid on its clock edge
  typedef struct packed {
    logic fire;
    logic wr;
    logic clr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } dpr_req_t;
endpackage : dpr_pkg

// >>> logic/dpr_port.sv
`timescale 1ns/10ps
module dpr_port #(
  parameter bit INV_CLK = 1'b0,
  parameter bit INV_EN = 1'b0,
  parameter bit INV_WE = 1'b0,
  parameter bit INV_CLR = 1'b0
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic port_clock,
  input wire logic enable,
  input wire logic write_strobe,
  input wire logic out_clear,
  input wire logic [dpr_pkg::ADDR_W-1:0] addr,
  input wire logic [dpr_pkg::DATA_W-1:0] write_word,
  output dpr_pkg::dpr_req_t req
);
  logic clk_eff;
  logic prev_clk_q;
  logic prev_clk_d;

  assign clk_eff = port_clock ^ INV_CLK;

  always_comb begin
    prev_clk_d = clk_eff;
  end

  // reset high so a pin already high at release gives no false edge
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      prev_clk_q <= 1'b1;
    end else begin
      prev_clk_q <= prev_clk_d;
    end
  end

  // sample all inputs together on edge
  always_comb begin
    req.fire = clk_eff & ~prev_clk_q & (enable ^ INV_EN);
    req.wr = write_strobe ^ INV_WE;
    req.clr = out_clear ^ INV_CLR;
    req.addr = addr;
    req.wdata = write_word;
  end
endmodule : dpr_port

// >>> logic/dpr_ram.sv
`timescale 1ns/10ps
// Behaviour
// - both ports share one 4096-cell array
// - address A selects W cells ending (A+1)*W-1
// - write-write collision leaves cells unknown
// - write-read collision: write ok, reader unknown
// - collision only on overlap with a write
// - inputs sampled together on port edge
// - enable, no write: read to output
// - enable and write: store and mirror
// - enable low: no access, output held
// - other port's write leaves output alone
// - read after clean write sees new value
// - each port has its own clock
// - array loaded from sixteen 256-bit slices
// - unset or short slices give zeros
// - slice n fills cells 256n to 256n+255
// - output clear zeroes output, not array
// - widths 1 to 16, address 12 to 8
// - clock, enable, write, clear invertible
module dpr_ram #(
  parameter int WIDTH_A = 16,
  parameter int WIDTH_B = 16,
  parameter logic [dpr_pkg::SLICES-1:0][dpr_pkg::SLICE_W-1:0] INIT_SLICES = '0,
  parameter bit INV_CLK_A = 1'b0,
  parameter bit INV_EN_A = 1'b0,
  parameter bit INV_WE_A = 1'b0,
  parameter bit INV_CLR_A = 1'b0,
  parameter bit INV_CLK_B = 1'b0,
  parameter bit INV_EN_B = 1'b0,
  parameter bit INV_WE_B = 1'b0,
  parameter bit INV_CLR_B = 1'b0
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic port_a_clock,
  input wire logic port_a_enable,
  input wire logic port_a_write,
  input wire logic port_a_clear,
  input wire logic [dpr_pkg::ADDR_W-1:0] port_a_addr,
  input wire logic [dpr_pkg::DATA_W-1:0] port_a_write_word,
  output logic [dpr_pkg::DATA_W-1:0] port_a_read_word,
  input wire logic port_b_clock,
  input wire logic port_b_enable,
  input wire logic port_b_write,
  input wire logic port_b_clear,
  input wire logic [dpr_pkg::ADDR_W-1:0] port_b_addr,
  input wire logic [dpr_pkg::DATA_W-1:0] port_b_write_word,
  output logic [dpr_pkg::DATA_W-1:0] port_b_read_word
);
  dpr_pkg::dpr_req_t req_a;
  dpr_pkg::dpr_req_t req_b;
  logic [dpr_pkg::CELLS-1:0] mem_q;
  logic [dpr_pkg::CELLS-1:0] mem_d;
  logic [dpr_pkg::DATA_W-1:0] rd_a_q;
  logic [dpr_pkg::DATA_W-1:0] rd_a_d;
  logic [dpr_pkg::DATA_W-1:0] rd_b_q;
  logic [dpr_pkg::DATA_W-1:0] rd_b_d;
  logic [dpr_pkg::BASE_W-1:0] base_a;
  logic [dpr_pkg::BASE_W-1:0] base_b;
  logic overlap;
  logic wr_a;
  logic wr_b;

  dpr_port #(
    .INV_CLK(INV_CLK_A),
    .INV_EN(INV_EN_A),
    .INV_WE(INV_WE_A),
    .INV_CLR(INV_CLR_A)
  ) u_port_a (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .port_clock(port_a_clock),
    .enable(port_a_enable),
    .write_strobe(port_a_write),
    .out_clear(port_a_clear),
    .addr(port_a_addr),
    .write_word(port_a_write_word),
    .req(req_a)
  );

  dpr_port #(
    .INV_CLK(INV_CLK_B),
    .INV_EN(INV_EN_B),
    .INV_WE(INV_WE_B),
    .INV_CLR(INV_CLR_B)
  ) u_port_b (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .port_clock(port_b_clock),
    .enable(port_b_enable),
    .write_strobe(port_b_write),
    .out_clear(port_b_clear),
    .addr(port_b_addr),
    .write_word(port_b_write_word),
    .req(req_b)
  );

  // address taken modulo the depth, so addresses past it wrap
  function automatic logic [dpr_pkg::BASE_W-1:0] cell_base(
    input logic [dpr_pkg::ADDR_W-1:0] a,
    input int w
  );
    int depth;
    int idx;
    depth = dpr_pkg::CELLS / w;
    idx = int'(a) % depth;
    cell_base = dpr_pkg::BASE_W'(idx * w);
  endfunction : cell_base

  function automatic logic [dpr_pkg::DATA_W-1:0] read_cells(
    input logic [dpr_pkg::CELLS-1:0] m,
    input logic [dpr_pkg::BASE_W-1:0] base,
    input int w
  );
    logic [dpr_pkg::DATA_W-1:0] v;
    v = '0;
    for (int i = 0; i < dpr_pkg::DATA_W; i++) begin
      if (i < w) begin
        v[i] = m[int'(base) + i];
      end
    end
    read_cells = v;
  endfunction : read_cells

  function automatic logic [dpr_pkg::DATA_W-1:0] trim(
    input logic [dpr_pkg::DATA_W-1:0] d,
    input int w
  );
    logic [dpr_pkg::DATA_W-1:0] v;
    v = '0;
    for (int i = 0; i < dpr_pkg::DATA_W; i++) begin
      if (i < w) begin
        v[i] = d[i];
      end
    end
    trim = v;
  endfunction : trim

  always_comb begin
    base_a = cell_base(req_a.addr, WIDTH_A);
    base_b = cell_base(req_b.addr, WIDTH_B);
    wr_a = req_a.fire & req_a.wr;
    wr_b = req_b.fire & req_b.wr;
    // same cycle edges on overlapping cells
    overlap = req_a.fire && req_b.fire &&
      (int'(base_a) < int'(base_b) + WIDTH_B) &&
      (int'(base_b) < int'(base_a) + WIDTH_A);
  end

  // array: one shared store
  always_comb begin
    mem_d = mem_q;
    for (int i = 0; i < dpr_pkg::DATA_W; i++) begin
      if (wr_a && i < WIDTH_A) begin
        mem_d[int'(base_a) + i] = req_a.wdata[i];
      end
    end
    for (int i = 0; i < dpr_pkg::DATA_W; i++) begin
      if (wr_b && i < WIDTH_B) begin
        mem_d[int'(base_b) + i] = req_b.wdata[i];
      end
    end
    // shared cells of two writes become unknown
    if (overlap && wr_a && wr_b) begin
      for (int i = 0; i < dpr_pkg::DATA_W; i++) begin
        if (i < WIDTH_A && int'(base_a) + i >= int'(base_b) &&
            int'(base_a) + i < int'(base_b) + WIDTH_B) begin
          mem_d[int'(base_a) + i] = 1'bx;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      mem_q <= INIT_SLICES;
    end else begin
      mem_q <= mem_d;
    end
  end

  // output registers; a read sees the array before this edge's writes
  always_comb begin
    rd_a_d = rd_a_q;
    rd_b_d = rd_b_q;
    // outputs only move on own enabled edge
    if (req_a.fire) begin
      if (req_a.clr) begin
        rd_a_d = dpr_pkg::OUT_RESET;
      end else if (req_a.wr) begin
        rd_a_d = trim(req_a.wdata, WIDTH_A);
      end else if (overlap && wr_b) begin
        rd_a_d = trim({dpr_pkg::DATA_W{1'bx}}, WIDTH_A);
      end else begin
        rd_a_d = read_cells(mem_q, base_a, WIDTH_A);
      end
    end
    if (req_b.fire) begin
      if (req_b.clr) begin
        rd_b_d = dpr_pkg::OUT_RESET;
      end else if (req_b.wr) begin
        rd_b_d = trim(req_b.wdata, WIDTH_B);
      end else if (overlap && wr_a) begin
        rd_b_d = trim({dpr_pkg::DATA_W{1'bx}}, WIDTH_B);
      end else begin
        rd_b_d = read_cells(mem_q, base_b, WIDTH_B);
      end
    end
  end

  // block starts disabled with zero outputs
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rd_a_q <= dpr_pkg::OUT_RESET;
      rd_b_q <= dpr_pkg::OUT_RESET;
    end else begin
      rd_a_q <= rd_a_d;
      rd_b_q <= rd_b_d;
    end
  end

  assign port_a_read_word = rd_a_q;
  assign port_b_read_word = rd_b_q;
endmodule : dpr_ram

// >>> verif/dpr_ram_chk.sv
`timescale 1ns/10ps
module dpr_ram_chk #(
  parameter int WIDTH_A = 16,
  parameter int WIDTH_B = 16
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic port_a_clock,
  input wire logic port_a_enable,
  input wire logic port_a_write,
  input wire logic port_a_clear,
  input wire logic [15:0] port_a_write_word,
  input wire logic [15:0] port_a_read_word,
  input wire logic port_b_clock,
  input wire logic port_b_enable,
  input wire logic port_b_write,
  input wire logic port_b_clear,
  input wire logic [15:0] port_b_write_word,
  input wire logic [15:0] port_b_read_word
);
  localparam logic [16:0] MASK_A = (17'h00001 << WIDTH_A) - 17'h00001;
  localparam logic [16:0] MASK_B = (17'h00001 << WIDTH_B) - 17'h00001;
  logic a_clk_q;
  logic b_clk_q;
  logic a_take;
  logic b_take;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // primed high: a clock already high at release is no edge
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      a_clk_q <= 1'b1;
      b_clk_q <= 1'b1;
    end else begin
      a_clk_q <= port_a_clock;
      b_clk_q <= port_b_clock;
    end
  end
  assign a_take = port_a_clock & ~a_clk_q & port_a_enable;
  assign b_take = port_b_clock & ~b_clk_q & port_b_enable;
  chk_reset_zero: assert property ($rose(rstn) |-> (port_a_read_word | port_b_read_word) == 16'h0000)
    else $error("read word not zero after reset");
  // collision results may hold unknown bits, so hold is compared exactly
  chk_a_hold: assert property (!a_take |=> port_a_read_word === $past(port_a_read_word))
    else $error("port a output moved without access");
  chk_b_hold: assert property (!b_take |=> port_b_read_word === $past(port_b_read_word))
    else $error("port b output moved without access");
  chk_a_mirror: assert property (a_take && port_a_write && !port_a_clear
    |=> port_a_read_word == ($past(port_a_write_word) & MASK_A[15:0]))
    else $error("port a write not mirrored");
  chk_b_mirror: assert property (b_take && port_b_write && !port_b_clear
    |=> port_b_read_word == ($past(port_b_write_word) & MASK_B[15:0]))
    else $error("port b write not mirrored");
  chk_a_clear: assert property (a_take && port_a_clear |=> port_a_read_word == 16'h0000)
    else $error("port a clear missed");
  chk_b_clear: assert property (b_take && port_b_clear |=> port_b_read_word == 16'h0000)
    else $error("port b clear missed");
  chk_b_upper_zero: assert property ((port_b_read_word & ~MASK_B[15:0]) == 16'h0000)
    else $error("port b bits above width not zero");
  cover property (a_take && b_take);
  cover property (a_take && port_a_clear);
  cover property (b_take && port_b_write);
endmodule : dpr_ram_chk

bind dpr_ram dpr_ram_chk #(.WIDTH_A(WIDTH_A), .WIDTH_B(WIDTH_B)) i_chk (
  .sys_clk, .rstn, .port_a_clock, .port_a_enable, .port_a_write, .port_a_clear,
  .port_a_write_word, .port_a_read_word, .port_b_clock, .port_b_enable,
  .port_b_write, .port_b_clear, .port_b_write_word, .port_b_read_word
);

// >>> verif/dpr_usr.sv
`timescale 1ns/10ps
module dpr_usr (
  input wire logic sys_clk,
  output logic pclk,
  output logic en,
  output logic wr,
  output logic clr,
  output logic [11:0] addr,
  output logic [15:0] word
);
  initial begin
    pclk = 1'b0;
    en = 1'b0;
    wr = 1'b0;
    clr = 1'b0;
    addr = 12'h000;
    word = 16'h0000;
  end
  // one access per call, clock low between
  task automatic acc(input int e, input int w, input int c,
                     input logic [11:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    pclk <= 1'b1;
    en <= e[0];
    wr <= w[0];
    clr <= c[0];
    addr <= a;
    word <= d;
    @(posedge sys_clk);
    pclk <= 1'b0;
    en <= 1'b0;
    // released address and data lines never show the stale value; wr and clr keep theirs
    addr <= ~a;
    word <= ~d;
    #1;
  endtask : acc
endmodule : dpr_usr

// >>> verif/tb.sv
`timescale 1ns/10ps
module tb;
  localparam logic [15:0][255:0] P_INIT = {16'hBEEF, 4064'h0, 16'hC0DE};
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  int fail_count = 0;
  int checks_done = 0;
  logic a_ck, a_en, a_wr, a_cl, b_ck, b_en, b_wr, b_cl;
  logic [11:0] a_ad, b_ad;
  logic [15:0] a_wd, b_wd, a_rd, b_rd;
  always #50 sys_clk = ~sys_clk;
  dpr_usr i_usr_a (.sys_clk(sys_clk), .pclk(a_ck), .en(a_en), .wr(a_wr), .clr(a_cl),
    .addr(a_ad), .word(a_wd));
  dpr_usr i_usr_b (.sys_clk(sys_clk), .pclk(b_ck), .en(b_en), .wr(b_wr), .clr(b_cl),
    .addr(b_ad), .word(b_wd));
  dpr_ram #(.WIDTH_A(16), .WIDTH_B(4), .INIT_SLICES(P_INIT)) i_dut (
    .sys_clk(sys_clk), .rstn(rstn), .port_a_clock(a_ck), .port_a_enable(a_en),
    .port_a_write(a_wr), .port_a_clear(a_cl), .port_a_addr(a_ad),
    .port_a_write_word(a_wd), .port_a_read_word(a_rd), .port_b_clock(b_ck),
    .port_b_enable(b_en), .port_b_write(b_wr), .port_b_clear(b_cl),
    .port_b_addr(b_ad), .port_b_write_word(b_wd), .port_b_read_word(b_rd));
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic results();
    $display("fail_count %0d checks_done %0d", fail_count, checks_done);
    if (fail_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results
  task automatic t_init();
    i_usr_a.acc(1, 0, 0, 12'h000, 16'h0000);
    cmp(a_rd, 16'hC0DE);
    i_usr_a.acc(1, 0, 0, 12'h0FF, 16'h0000);
    cmp(a_rd, 16'hBEEF);
    i_usr_b.acc(1, 0, 0, 12'h001, 16'h0000);
    cmp(b_rd, 16'h000D);
    i_usr_b.acc(1, 0, 0, 12'h010, 16'h0000);
    cmp(b_rd, 16'h0000);
  endtask : t_init
  task automatic t_rw();
    i_usr_a.acc(1, 1, 0, 12'h005, 16'hA5C3);
    cmp(a_rd, 16'hA5C3);
    i_usr_a.acc(0, 1, 0, 12'h005, 16'hFFFF);
    cmp(a_rd, 16'hA5C3);
    i_usr_b.acc(1, 0, 0, 12'h014, 16'h0000);
    cmp(b_rd, 16'h0003);
    i_usr_b.acc(1, 0, 0, 12'h017, 16'h0000);
    cmp(b_rd, 16'h000A);
    i_usr_b.acc(1, 0, 0, 12'h414, 16'h0000);
    cmp(b_rd, 16'h0003);
    i_usr_a.acc(1, 0, 0, 12'h005, 16'h0000);
    cmp(a_rd, 16'hA5C3);
  endtask : t_rw
  task automatic t_iso();
    i_usr_b.acc(1, 1, 0, 12'h015, 16'h0009);
    cmp(a_rd, 16'hA5C3);
    i_usr_a.acc(1, 0, 0, 12'h005, 16'h0000);
    cmp(a_rd, 16'hA593);
  endtask : t_iso
  task automatic t_clr();
    i_usr_a.acc(1, 1, 1, 12'h006, 16'h1111);
    cmp(a_rd, 16'h0000);
    cmp(b_rd, 16'h0009);
    i_usr_a.acc(1, 0, 0, 12'h006, 16'h0000);
    cmp(a_rd, 16'h1111);
    i_usr_b.acc(1, 0, 1, 12'h015, 16'h0000);
    cmp(b_rd, 16'h0000);
  endtask : t_clr
  task automatic t_coll();
    fork
      i_usr_a.acc(1, 1, 0, 12'h007, 16'hFFFF);
      i_usr_b.acc(1, 1, 0, 12'h01C, 16'h0005);
    join
    cmp(a_rd, 16'hFFFF);
    cmp(b_rd, 16'h0005);
    i_usr_a.acc(1, 0, 0, 12'h007, 16'h0000);
    cmp(a_rd, {12'hFFF, 4'hX});
    fork
      i_usr_a.acc(1, 0, 0, 12'h008, 16'h0000);
      i_usr_b.acc(1, 1, 0, 12'h020, 16'h0006);
    join
    cmp(b_rd, 16'h0006);
    cmp(a_rd, 16'hXXXX);
    i_usr_a.acc(1, 0, 0, 12'h008, 16'h0000);
    cmp(a_rd, 16'h0006);
    fork
      i_usr_a.acc(1, 1, 0, 12'h009, 16'h2222);
      i_usr_b.acc(1, 0, 0, 12'h014, 16'h0000);
    join
    cmp(b_rd, 16'h0003);
  endtask : t_coll
  initial begin
    repeat (10) @(posedge sys_clk);
    rstn <= 1'b1;
    t_init();
    t_rw();
    t_iso();
    t_clr();
    t_coll();
    results();
  end
  initial begin
    #100000;
    fail_count++;
    results();
  end
endmodule : tb
